// >>> verilog/reply_capture.sv
`timescale 1ns/1ps
`default_nettype none
// reply capture and queue status registers
module reply_capture (
    input wire logic clk_sys, // 40 MHz clock
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, next cycle
    input wire logic [5:0] card_index, // reply index from card
    input wire logic [119:0] card_bits, // reply bits 127:8
    input wire logic card_valid, // reply complete pulse
    output logic card_ready, // buffer can take reply
    output logic [2:0] reply_format, // format of pending command
    output logic cmd_start, // command write pulse
    input wire logic [7:0] rx_held, // bytes held in rx queue
    input wire logic [7:0] tx_free, // bytes free in tx queue
    output logic rx_flush, // rx flush pulse
    output logic tx_flush // tx flush pulse
);
    logic [5:0] last_index, next_last_index;
    logic [31:0] word0, word1, word2, word3;
    logic [31:0] next_word0, next_word1, next_word2, next_word3;
    logic [2:0] fmt, next_fmt;
    reply_pkg::seq_t state, next_state;
    logic [31:0] next_rdata;
    logic next_cmd_start, next_rx_flush, next_tx_flush;
    logic [7:0] rx_held_q, tx_free_q, next_rx_held_q, next_tx_free_q;
    logic [133:0] buf_out;
    logic buf_valid, buf_take, buf_in_ready;
    logic next_card_ready;
    logic cmd_wr, queue_wr, capture;
    logic [2:0] cmd_fmt;

    // decode a format code into its long-reply class
    function automatic logic fmt_is_long(input logic [2:0] f);
        return (f == reply_pkg::FMT_R2) || (f == reply_pkg::FMT_R3);
    endfunction

    // decode a strobe aimed at one register offset
    function automatic logic bus_hit(input logic strobe,
        input logic [7:0] a, input logic [7:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // reply buffer: drained every cycle, card side never stalls on software reads
    skid_pair u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .in_data({card_index, card_bits, 8'h00}),
        .in_valid(card_valid),
        .in_ready(buf_in_ready),
        .out_data(buf_out),
        .out_valid(buf_valid),
        .out_ready(buf_take)
    );

    // command register write and its format field
    assign cmd_wr = bus_hit(wr, addr, reply_pkg::OFS_CMD);
    assign cmd_fmt = wdata[reply_pkg::CMD_TYPE_LSB +: 3];
    // queue register write, source of the flush strobes
    assign queue_wr = bus_hit(wr, addr, reply_pkg::OFS_QUEUE);
    // a reply is taken only while one is awaited
    assign capture = (state == reply_pkg::WAIT) && buf_valid;
    // every reply leaves the buffer at once, stale ones are lost
    assign buf_take = buf_valid;

    // capture sequence next state
    always_comb begin
        next_state = state;
        case (state)
            reply_pkg::IDLE: begin
                // late replies are drained and dropped
                next_state = reply_pkg::IDLE;
            end
            reply_pkg::WAIT: begin
                // first reply of the command ends the wait
                if (buf_valid) begin
                    next_state = reply_pkg::DONE;
                end
            end
            reply_pkg::DONE: begin
                // holds until the next command write
                next_state = reply_pkg::DONE;
            end
            default: begin
                next_state = reply_pkg::IDLE;
            end
        endcase
        if (cmd_wr) begin
            if (cmd_fmt == reply_pkg::FMT_NONE) begin
                next_state = reply_pkg::IDLE;
            end else begin
                next_state = reply_pkg::WAIT;
            end
        end
    end

    // capture sequence register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= reply_pkg::IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // format code latched on command write
    always_comb begin
        next_fmt = fmt;
        // a command written while waiting replaces the format
        if (cmd_wr) begin
            next_fmt = cmd_fmt;
        end
    end

    // format register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fmt <= reply_pkg::FMT_R1;
        end else if (ce) begin
            fmt <= next_fmt;
        end
    end

    // reply index next value
    always_comb begin
        next_last_index = last_index;
        // only the first reply of a command is taken
        if (capture) begin
            if (fmt_is_long(fmt)) begin
                next_last_index = reply_pkg::LONG_INDEX;
            end else begin
                next_last_index = buf_out[133:128];
            end
        end
    end

    // reply index register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_index <= 6'h00;
        end else if (ce) begin
            last_index <= next_last_index;
        end
    end

    // word zero takes reply bits 39:8 of every captured reply
    always_comb begin
        next_word0 = word0;
        if (capture) begin
            // status word or the low identity bits
            next_word0 = buf_out[39:8];
        end
    end

    // word zero register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            word0 <= reply_pkg::RESET_WORD;
        end else if (ce) begin
            word0 <= next_word0;
        end
    end

    // long reply spread over the upper words
    always_comb begin
        next_word1 = word1;
        next_word2 = word2;
        next_word3 = word3;
        // short replies leave these words alone
        if (capture && fmt == reply_pkg::FMT_R2) begin
            next_word1 = buf_out[71:40];
            next_word2 = buf_out[103:72];
            // top byte of word three stays reserved
            next_word3 = {8'h00, buf_out[127:104]};
        end
    end

    // upper word registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            word1 <= reply_pkg::RESET_WORD;
            word2 <= reply_pkg::RESET_WORD;
            word3 <= reply_pkg::RESET_WORD;
        end else if (ce) begin
            word1 <= next_word1;
            word2 <= next_word2;
            word3 <= next_word3;
        end
    end

    // command strobe toward the link logic
    always_comb begin
        // stands one cycle after the write
        next_cmd_start = cmd_wr;
    end

    // command strobe register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_start <= 1'b0;
        end else if (ce) begin
            cmd_start <= next_cmd_start;
        end
    end

    // flush strobes, bits read back as zero
    always_comb begin
        next_rx_flush = 1'b0;
        next_tx_flush = 1'b0;
        if (queue_wr) begin
            next_rx_flush = wdata[reply_pkg::RX_FLUSH_BIT];
            next_tx_flush = wdata[reply_pkg::TX_FLUSH_BIT];
        end
    end

    // flush strobe registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
        end else if (ce) begin
            rx_flush <= next_rx_flush;
            tx_flush <= next_tx_flush;
        end
    end

    always_comb begin
        // no synchroniser: both counts come from this clock
        next_rx_held_q = rx_held;
        next_tx_free_q = tx_free;
    end

    // queue level registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_held_q <= reply_pkg::RX_HELD_RESET;
            tx_free_q <= reply_pkg::TX_FREE_RESET;
        end else if (ce) begin
            rx_held_q <= next_rx_held_q;
            tx_free_q <= next_tx_free_q;
        end
    end

    // room in the reply buffer, registered toward the card
    always_comb begin
        // lags one cycle, the two entries cover the lag
        next_card_ready = buf_in_ready;
    end

    // ready register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            card_ready <= 1'b0;
        end else if (ce) begin
            card_ready <= next_card_ready;
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        next_rdata = reply_pkg::RESET_WORD;
        if (rd) begin
            case (addr)
                // command register mirror, format only
                reply_pkg::OFS_CMD: next_rdata = {21'h0, fmt, 8'h00};
                reply_pkg::OFS_INDEX: next_rdata = {26'h0, last_index};
                // captured reply words
                reply_pkg::OFS_WORD0: next_rdata = word0;
                reply_pkg::OFS_WORD1: next_rdata = word1;
                reply_pkg::OFS_WORD2: next_rdata = word2;
                reply_pkg::OFS_WORD3: next_rdata = word3;
                reply_pkg::OFS_QUEUE: next_rdata = {16'h0, rx_held_q, tx_free_q};
                // unmapped offsets
                default: next_rdata = reply_pkg::RESET_WORD;
            endcase
        end
    end

    // read data register, zero when no read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= reply_pkg::RESET_WORD;
        end else if (ce) begin
            rdata <= next_rdata;
        end
    end

    // format seen by the card side
    assign reply_format = fmt;
endmodule
`default_nettype wire

// >>> verilog/reply_pkg.sv
// What this block does
// - capture reply command index, six bits
// - long or R3 replies show all ones
// - reply word zero read-only, resets zero
// - short replies fill only word zero
// - long reply spread over four words
// - write one bit 31 flushes receive
// - write one bit 30 flushes transmit
// - report bytes held in receive queue
// - report free transmit bytes, reset 0x80
// - three-bit reply format code decoded
// - replies refresh only after command write
package reply_pkg;
    localparam logic [7:0] OFS_CMD = 8'h1C;
    localparam logic [7:0] OFS_INDEX = 8'h20;
    localparam logic [7:0] OFS_WORD0 = 8'h24;
    localparam logic [7:0] OFS_WORD1 = 8'h28;
    localparam logic [7:0] OFS_WORD2 = 8'h2C;
    localparam logic [7:0] OFS_WORD3 = 8'h30;
    localparam logic [7:0] OFS_QUEUE = 8'h34;
    localparam int CMD_INDEX_LSB = 0;
    localparam int CMD_TYPE_LSB = 8;
    localparam int RX_FLUSH_BIT = 31;
    localparam int TX_FLUSH_BIT = 30;
    localparam int RX_COUNT_LSB = 8;
    localparam int TX_COUNT_LSB = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [7:0] TX_FREE_RESET = 8'h80;
    localparam logic [7:0] RX_HELD_RESET = 8'h00;
    localparam logic [5:0] LONG_INDEX = 6'h3F;
    localparam logic [2:0] FMT_R1 = 3'h0;
    localparam logic [2:0] FMT_R1B = 3'h1;
    localparam logic [2:0] FMT_R2 = 3'h2;
    localparam logic [2:0] FMT_R3 = 3'h3;
    localparam logic [2:0] FMT_NONE = 3'h4;
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        WAIT = 2'b01,
        DONE = 2'b11
    } seq_t;
endpackage

// >>> verilog/skid_pair.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer, valid/ready both sides
module skid_pair (
    input wire logic clk_sys, // clock
    input wire logic rst, // async reset
    input wire logic ce, // clock enable
    input wire logic [133:0] in_data, // word in
    input wire logic in_valid, // word offered
    output logic in_ready, // room free
    output logic [133:0] out_data, // word out
    output logic out_valid, // word held
    input wire logic out_ready // taker ready
);
    logic [133:0] mem [2];
    logic [133:0] next_mem [2];
    logic wp, rp, next_wp, next_rp;
    logic [1:0] cnt, next_cnt;
    logic push, pop;

    // pointer and storage update
    always_comb begin
        push = in_valid && (cnt != 2'h2);
        pop = out_ready && (cnt != 2'h0);
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push) begin
            next_mem[wp] = in_data;
            next_wp = ~wp;
        end
        if (pop) begin
            next_rp = ~rp;
        end
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else if (ce) begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rp];
endmodule
`default_nettype wire

// >>> tb/reply_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for reply capture
module reply_asserts (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic [7:0] addr, // address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [31:0] rdata, // read data
    input wire logic [2:0] reply_format, // format
    input wire logic cmd_start, // command pulse
    input wire logic rx_flush, // rx flush
    input wire logic tx_flush // tx flush
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // taken accesses
    sequence s_rd(a);
        rd && ce && addr == a;
    endsequence
    sequence s_wr(a);
        wr && ce && addr == a;
    endsequence
    property p_index; s_rd(8'h20) |=> rdata[31:6] == 26'h0; endproperty
    property p_word3; s_rd(8'h30) |=> rdata[31:24] == 8'h0; endproperty
    property p_queue; s_rd(8'h34) |=> rdata[31:16] == 16'h0; endproperty
    property p_idle; ce && !rd |=> rdata == 32'h0; endproperty
    property p_rx_flush;
        ce |=> rx_flush == $past(wr && addr == 8'h34 && wdata[31]);
    endproperty
    property p_tx_flush; s_wr(8'h34) ##0 wdata[30] |=> tx_flush; endproperty
    property p_tx_end;
        ce && !(wr && addr == 8'h34 && wdata[30]) |=> !tx_flush;
    endproperty
    property p_cmd; s_wr(8'h1C) |=> cmd_start; endproperty
    property p_cmd_end;
        ce && !(wr && addr == 8'h1C) |=> !cmd_start;
    endproperty
    property p_format;
        s_wr(8'h1C) |=> reply_format == $past(wdata[10:8]);
    endproperty
    a_index: assert property (p_index) else $error("index high bits");
    a_word3: assert property (p_word3) else $error("word3 high bits");
    a_queue: assert property (p_queue) else $error("queue high bits");
    a_idle: assert property (p_idle) else $error("rdata not idle");
    a_rx_flush: assert property (p_rx_flush) else $error("rx flush");
    a_tx_flush: assert property (p_tx_flush) else $error("tx flush");
    a_tx_end: assert property (p_tx_end) else $error("tx flush end");
    a_cmd: assert property (p_cmd) else $error("command pulse");
    a_cmd_end: assert property (p_cmd_end) else $error("command end");
    a_format: assert property (p_format) else $error("format");
endmodule
bind reply_capture reply_asserts chk (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .reply_format(reply_format), .cmd_start(cmd_start),
    .rx_flush(rx_flush), .tx_flush(tx_flush));
`default_nettype wire

// >>> tb/card_model.sv
`timescale 1ns/1ps
`default_nettype none
// card answering a command after a delay
module card_model (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic cmd_start, // command sent
    input wire logic [2:0] reply_format, // expected reply
    input wire logic card_ready, // host can take
    input wire logic [5:0] rep_index, // index to return
    input wire logic [119:0] rep_bits, // bits to return
    output logic [5:0] card_index, // reply index
    output logic [119:0] card_bits, // reply bits
    output logic card_valid // reply offered
);
    logic [3:0] dly;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dly <= 4'h0;
            card_valid <= 1'b0;
        end else begin
            dly <= {dly[2:0], cmd_start && reply_format != 3'h4};
            if (dly[3])
                card_valid <= 1'b1;
            else if (card_ready)
                card_valid <= 1'b0;
        end
    end
    // lines show garbage when idle
    assign card_index = card_valid ? rep_index : ~rep_index;
    assign card_bits = card_valid ? rep_bits : ~rep_bits;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk_sys = 0, rst = 1, ce = 1, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, rx_held = 8'h00, tx_free = 8'h80;
    logic [31:0] wdata = 32'h0, rdata;
    logic [5:0] rep_index = 6'h0, card_index;
    logic [119:0] rep_bits = 120'h0, card_bits, b;
    logic card_valid, card_ready, cmd_start, rx_flush, tx_flush;
    logic [2:0] reply_format, f;
    int err_count = 0, comparisons = 0, cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    reply_capture uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .card_index(card_index), .card_bits(card_bits),
        .card_valid(card_valid), .card_ready(card_ready),
        .reply_format(reply_format), .cmd_start(cmd_start),
        .rx_held(rx_held), .tx_free(tx_free), .rx_flush(rx_flush),
        .tx_flush(tx_flush));
    card_model partner (.clk_sys(clk_sys), .rst(rst), .cmd_start(cmd_start),
        .reply_format(reply_format), .card_ready(card_ready),
        .rep_index(rep_index), .rep_bits(rep_bits), .card_index(card_index),
        .card_bits(card_bits), .card_valid(card_valid));
    // bus cycles
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    // issue a command, card answers with i and x unless t is 3'h4
    task automatic cmd(input logic [2:0] t, input logic [5:0] i,
        input logic [119:0] x);
        @(posedge clk_sys);
        rep_index <= i;
        rep_bits <= x;
        wr_reg(8'h1C, {21'h0, t, 8'h07});
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++)
            rd_chk(8'h20 + 8'(4 * k), 32'h0);
        rd_chk(8'h34, 32'h0000_0080);
        rd_chk(8'h3C, 32'h0);
        `CHK("card_ready", 1'b1, card_ready)
        $display("reset test done");
        b = {4{30'h2AC35E1D}};
        cmd(3'h2, 6'h02, b);
        rd_chk(8'h20, 32'h3F);
        rd_chk(8'h24, b[31:0]);
        rd_chk(8'h28, b[63:32]);
        rd_chk(8'h2C, b[95:64]);
        rd_chk(8'h30, {8'h0, b[119:96]});
        $display("long reply test done");
        for (int k = 0; k < 3; k++) begin
            f = k == 2 ? 3'h3 : 3'(k);
            cmd(f, 6'(k + 13), ~b + 120'(k));
            rd_chk(8'h20, k == 2 ? 32'h3F : 32'(k + 13));
            rd_chk(8'h24, ~b[31:0] + 32'(k));
            rd_chk(8'h28, b[63:32]);
        end
        $display("short reply test done");
        cmd(3'h4, 6'h21, b);
        wr_reg(8'h24, 32'hFFFF_FFFF);
        rd_chk(8'h20, 32'h3F);
        rd_chk(8'h24, ~b[31:0] + 32'h2);
        $display("no reply test done");
        @(posedge clk_sys);
        rx_held <= 8'h2A;
        tx_free <= 8'h11;
        wr_reg(8'h34, 32'hC000_0000);
        `CHK("rx_flush", 1'b1, rx_flush)
        `CHK("tx_flush", 1'b1, tx_flush)
        rd_chk(8'h34, 32'h0000_2A11);
        wr_reg(8'h34, 32'h4000_0000);
        `CHK("rx_flush", 1'b0, rx_flush)
        `CHK("tx_flush", 1'b1, tx_flush)
        @(posedge clk_sys);
        ce <= 1'b0;
        wr_reg(8'h34, 32'hC000_0000);
        `CHK("rx_flush", 1'b0, rx_flush)
        `CHK("tx_flush", 1'b0, tx_flush)
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("queue test done");
        summarize();
    end
endmodule
`default_nettype wire
